// ### uart_data_port.sv
/*
  uart shared data port with receive and transmit fifos, divisor access,
  line status, interrupt status and an axi4-lite register slave.
  assumes one aclk domain; sin is asynchronous and synchronised downstream.
*/
`timescale 1ns/1ps
module uart_data_port
  import uart_port_pkg::*;
#(
  parameter int FIFO_DEPTH = FIFO_DEPTH_DEF
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [31:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic sin,
  output logic sout,
  output logic irq
);
  localparam int AW = $clog2(FIFO_DEPTH);
  localparam int CW = AW + 1;
  localparam logic [CW-1:0] FULL = CW'(FIFO_DEPTH);
  localparam logic [CW-1:0] ONE = CW'(1);

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  function automatic logic mapped(input logic [31:0] a);
    return a == DATA_ADDR || a == DLH_ADDR || a == FCR_ADDR || a == LCR_ADDR || a == LSR_ADDR
      || a == IRQ_STAT_ADDR || a == IRQ_CLR_ADDR || a == IRQ_EN_ADDR;
  endfunction : mapped

  uart_link_if lnk ();

  uart_serial_engine engine (
    .aclk(aclk),
    .aresetn(aresetn),
    .sin(sin),
    .sout(sout),
    .lnk(lnk)
  );

  logic aw_held;
  logic w_held;
  logic [31:0] aw_addr;
  logic [7:0] wb;
  logic w_lane0;
  logic [7:0] line_control_reg;
  logic fifo_en;
  logic [7:0] dll;
  logic [7:0] dlh;
  logic oe;
  logic [2:0] irq_stat;
  logic [2:0] irq_en;
  logic [7:0] rx_mem [FIFO_DEPTH];
  logic [7:0] tx_mem [FIFO_DEPTH];
  logic [AW-1:0] rx_head;
  logic [AW-1:0] rx_tail;
  logic [AW-1:0] tx_head;
  logic [AW-1:0] tx_tail;
  logic [CW-1:0] rx_count;
  logic [CW-1:0] tx_count;

  // bus decode
  wire wr_go = aw_held && w_held && !bvalid;
  wire wr_en = wr_go && w_lane0;
  wire rd_go = arvalid && arready;
  wire divisor_access_bit = line_control_reg[LCR_DIVISOR_ACCESS_BIT];
  wire wr_data = wr_en && aw_addr == DATA_ADDR;
  wire wr_dlh = wr_en && aw_addr == DLH_ADDR;
  wire wr_fcr = wr_en && aw_addr == FCR_ADDR;
  wire wr_lcr = wr_en && aw_addr == LCR_ADDR;
  wire wr_clr = wr_en && aw_addr == IRQ_CLR_ADDR;
  wire wr_ien = wr_en && aw_addr == IRQ_EN_ADDR;
  wire rd_data = rd_go && araddr == DATA_ADDR;
  wire rd_lsr = rd_go && araddr == LSR_ADDR;
  // changing fifo mode empties both queues
  wire flush = wr_fcr && wb[FCR_EN] != fifo_en;

  // receive queue
  wire dr = rx_count != '0;
  wire rx_full = rx_count == FULL;
  wire rx_push = lnk.rx_valid;
  wire rx_pop = rd_data && !divisor_access_bit && dr;
  wire rx_ow = rx_push && !fifo_en && dr && !rx_pop;
  wire rx_wr = rx_push && (!fifo_en || !rx_full || rx_pop);
  wire rx_adv = rx_wr && !rx_ow;
  wire [AW-1:0] rx_idx = rx_ow ? rx_head : rx_tail;
  wire overrun_ev = rx_push && !rx_pop && (fifo_en ? rx_full : dr);

  // transmit queue
  wire tx_holding_empty_flag = tx_count == '0;
  wire tx_full = tx_count == FULL;
  wire tx_pop = lnk.tx_valid && lnk.tx_ready;
  wire tx_wr = wr_data && !divisor_access_bit;
  wire tx_acc = tx_wr && (!fifo_en || !tx_full);
  wire tx_ow = tx_wr && !fifo_en && !tx_holding_empty_flag && !tx_pop;
  wire tx_adv = tx_acc && !tx_ow;
  wire [AW-1:0] tx_idx = tx_ow ? tx_head : tx_tail;

  wire [2:0] events = {tx_pop && tx_count == ONE && !tx_acc, overrun_ev, rx_wr};
  wire [2:0] clr_mask = wr_clr ? wb[2:0] : 3'h0;
  wire [7:0] line_status_reg = {1'b0, tx_holding_empty_flag && lnk.tx_idle, tx_holding_empty_flag, 3'h0, oe, dr};
  wire [7:0] rx_byte = dr ? rx_mem[rx_head] : BYTE_RESET;
  wire [7:0] data_rd = divisor_access_bit ? dll : rx_byte;
  wire [31:0] rd_val =
    araddr == DATA_ADDR ? {16'h0000, DATA_RESET[15:8], data_rd} :
    araddr == DLH_ADDR ? {24'h000000, dlh} :
    araddr == FCR_ADDR ? {31'h00000000, fifo_en} :
    araddr == LCR_ADDR ? {24'h000000, line_control_reg} :
    araddr == LSR_ADDR ? {24'h000000, line_status_reg} :
    araddr == IRQ_STAT_ADDR ? {29'h00000000, irq_stat} :
    araddr == IRQ_EN_ADDR ? {29'h00000000, irq_en} : 32'h00000000;

  assign awready = !aw_held && !bvalid;
  assign wready = !w_held && !bvalid;
  assign arready = !rvalid;
  assign irq = |(irq_stat & irq_en);
  assign lnk.divisor = {dlh, dll};
  assign lnk.tx_valid = !tx_holding_empty_flag;
  assign lnk.tx_data = tx_mem[tx_head];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 32'h00000000;
      wb <= BYTE_RESET;
      w_lane0 <= 1'b0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_held <= 1'b1;
        aw_addr <= awaddr;
      end else if (wr_go) aw_held <= 1'b0;
      if (wvalid && wready) begin
        w_held <= 1'b1;
        wb <= wdata[7:0];
        w_lane0 <= wstrb[0];
      end else if (wr_go) w_held <= 1'b0;
      if (wr_go) begin
        bvalid <= 1'b1;
        bresp <= mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
      end else if (bready) bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= RESP_OKAY;
    end else if (rd_go) begin
      rvalid <= 1'b1;
      rdata <= rd_val;
      rresp <= mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (rready) rvalid <= 1'b0;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      line_control_reg <= BYTE_RESET;
      fifo_en <= 1'b0;
      dll <= BYTE_RESET;
      dlh <= BYTE_RESET;
      oe <= 1'b0;
      irq_stat <= 3'h0;
      irq_en <= 3'h0;
    end else begin
      if (wr_lcr) line_control_reg <= wb;
      if (wr_fcr) fifo_en <= wb[FCR_EN];
      if (wr_data && divisor_access_bit) dll <= wb;
      if (wr_dlh && divisor_access_bit) dlh <= wb;
      if (wr_ien) irq_en <= wb[2:0];
      oe <= (oe && !rd_lsr) || overrun_ev;
      irq_stat <= (irq_stat & ~clr_mask) | events;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || flush) begin
      rx_head <= '0;
      rx_tail <= '0;
      rx_count <= '0;
    end else begin
      if (rx_pop) rx_head <= rx_head + AW'(1);
      if (rx_adv) rx_tail <= rx_tail + AW'(1);
      rx_count <= rx_count + CW'(rx_adv) - CW'(rx_pop);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || flush) begin
      tx_head <= '0;
      tx_tail <= '0;
      tx_count <= '0;
    end else begin
      if (tx_pop) tx_head <= tx_head + AW'(1);
      if (tx_adv) tx_tail <= tx_tail + AW'(1);
      tx_count <= tx_count + CW'(tx_adv) - CW'(tx_pop);
    end
  end

  always_ff @(posedge aclk) begin
    if (rx_wr) rx_mem[rx_idx] <= lnk.rx_data;
    if (tx_acc) tx_mem[tx_idx] <= wb;
  end

  rx_read_a: assert property (rd_data && !divisor_access_bit && dr
    |=> rvalid && rdata[7:0] == $past(rx_mem[rx_head]))
    else $error("data port read does not return fifo head");
  dr_set_a: assert property (rx_wr && !flush
    |=> dr)
    else $error("stored byte did not raise data ready");
  rx_overwrite_a: assert property (!fifo_en && rx_count == ONE && rx_push && !rx_pop && !flush
    |=> rx_count == ONE && oe && rx_mem[rx_head] == $past(lnk.rx_data))
    else $error("unread byte not overwritten with overrun");
  oe_set_a: assert property (overrun_ev
    |=> oe)
    else $error("overrun event did not set overrun flag");
  oe_clear_a: assert property (rd_lsr && !overrun_ev
    |=> !oe)
    else $error("line status read did not clear overrun");
  fifo_off_one_a: assert property (!fifo_en
    |-> rx_count <= ONE && tx_count <= ONE)
    else $error("queue deeper than one with fifos off");
  rx_pop_a: assert property (rx_pop && !rx_push && !flush
    |=> rx_count == $past(rx_count) - ONE)
    else $error("read did not pop receive fifo");
  rx_keep_a: assert property (fifo_en && rx_full && rx_push && !rx_pop && !flush
    |=> rx_full && oe && $stable(rx_tail))
    else $error("full receive fifo altered on overrun");
  count_bound_a: assert property (rx_count <= FULL
    && tx_count <= FULL)
    else $error("fifo count beyond depth");
  tx_holding_empty_flag_clear_a: assert property (!fifo_en && tx_holding_empty_flag && tx_wr && !flush
    |=> !tx_holding_empty_flag && tx_count == ONE)
    else $error("holding empty not cleared by write");
  tx_holding_empty_flag_set_a: assert property (tx_pop && tx_count == ONE && !tx_acc && !flush
    |=> tx_holding_empty_flag)
    else $error("holding empty not set when queue drained");
  tx_replace_a: assert property (tx_ow && !flush
    |=> tx_count == ONE && tx_mem[tx_head] == $past(wb))
    else $error("pending transmit byte not replaced");
  tx_fill_a: assert property (fifo_en && tx_count == FULL - ONE && tx_acc && !tx_pop && !flush
    |=> tx_full)
    else $error("sixteenth write did not fill fifo");
  tx_drop_a: assert property (fifo_en && tx_full && tx_wr && !tx_pop && !flush
    |=> tx_full && $stable(tx_tail))
    else $error("write to full transmit fifo not dropped");
  reset_zero_a: assert property ($rose(aresetn)
    |-> rdata == 32'h00000000 && rx_count == '0 && dll == BYTE_RESET)
    else $error("data port not zero after reset");
  reserved_zero_a: assert property (rd_go && araddr == DATA_ADDR
    |=> rdata[31:8] == 24'h000000)
    else $error("reserved data port bits not zero");
  divisor_low_a: assert property (wr_data && divisor_access_bit
    |=> dll == $past(wb) && tx_count == $past(tx_count) - CW'($past(tx_pop)))
    else $error("divisor access did not reach low byte");
  divisor_access_bit_no_pop_a: assert property (rd_data && divisor_access_bit && !flush
    |=> rx_count == $past(rx_count) + CW'($past(rx_adv)))
    else $error("divisor access read popped receive fifo");
  dr_clear_a: assert property (rx_pop && rx_count == ONE && !rx_push
    |=> !dr ##1 (!dr || $past(rx_push)))
    else $error("data ready not cleared by last read");
  write_answer_a: assert property (wr_go
    |=> bvalid && !awready && !wready)
    else $error("write not answered one cycle after both channels");
  read_answer_a: assert property (rd_go
    |=> rvalid && !arready)
    else $error("read not answered one cycle after address");
  irq_clear_a: assert property (wr_clr && events == 3'h0
    |=> (irq_stat & $past(clr_mask)) == 3'h0)
    else $error("interrupt status not cleared by clear write");
  flush_empty_a: assert property (flush
    |=> rx_count == '0 && tx_count == '0)
    else $error("fifo mode change did not empty queues");
endmodule : uart_data_port

// ### uart_port_pkg.sv
/*
  constants for the uart data port: register addresses, field positions,
  reset values, serial timing and the serial engine state type.
  assumes a 32-bit axi4-lite address space with one word per register.
*/
package uart_port_pkg;
  localparam logic [31:0] DATA_ADDR = 32'h5000_1000;
  localparam logic [31:0] DLH_ADDR = 32'h5000_1004;
  localparam logic [31:0] FCR_ADDR = 32'h5000_1008;
  localparam logic [31:0] LCR_ADDR = 32'h5000_100c;
  localparam logic [31:0] LSR_ADDR = 32'h5000_1014;
  localparam logic [31:0] IRQ_STAT_ADDR = 32'h5000_1020;
  localparam logic [31:0] IRQ_CLR_ADDR = 32'h5000_1024;
  localparam logic [31:0] IRQ_EN_ADDR = 32'h5000_1028;
  localparam int LCR_DIVISOR_ACCESS_BIT = 7;
  localparam int FCR_EN = 0;
  localparam int LSR_DR = 0;
  localparam int LSR_OE = 1;
  localparam int LSR_TX_HOLDING_EMPTY_FLAG = 5;
  localparam int LSR_TEMT = 6;
  localparam int EV_RX = 0;
  localparam int EV_OE = 1;
  localparam int EV_TX_HOLDING_EMPTY_FLAG = 2;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [15:0] DATA_RESET = 16'h0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int FIFO_DEPTH_DEF = 16;
  localparam logic [3:0] BIT_LAST = 4'hf;
  localparam logic [3:0] BIT_MID = 4'h7;
  typedef enum logic [3:0] {
    S_IDLE = 4'h1,
    S_START = 4'h2,
    S_DATA = 4'h4,
    S_STOP = 4'h8
  } serial_state_t;
endpackage : uart_port_pkg

// ### uart_link_if.sv
/*
  link between the data port core and the serial engine.
  assumes both ends run on the same aclk.
*/
`timescale 1ns/1ps
interface uart_link_if;
  logic [7:0] tx_data;
  logic tx_valid;
  logic tx_ready;
  logic tx_idle;
  logic [7:0] rx_data;
  logic rx_valid;
  logic [15:0] divisor;
  modport engine (input tx_data, tx_valid, divisor, output tx_ready, tx_idle, rx_data, rx_valid);
  modport core (output tx_data, tx_valid, divisor, input tx_ready, tx_idle, rx_data, rx_valid);
endinterface : uart_link_if

// ### uart_serial_engine.sv
/*
  baud generator, 8n1 transmitter and receiver with 16x oversampling.
  assumes sin is asynchronous; the core supplies the divisor.
*/
`timescale 1ns/1ps
module uart_serial_engine
  import uart_port_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic sin,
  output logic sout,
  uart_link_if.engine lnk
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic [15:0] div_cnt;
  logic tick;
  serial_state_t tx_st;
  serial_state_t rx_st;
  logic [3:0] tx_tk;
  logic [3:0] rx_tk;
  logic [2:0] tx_bit;
  logic [2:0] rx_bit;
  logic [7:0] tx_sh;
  logic [7:0] rx_sh;
  logic sin_meta;
  logic sin_s;
  logic tx_last;
  logic rx_last;

  // one tick per divisor cycles, sixteen ticks per bit; zero stops it
  assign tick = (lnk.divisor != 16'h0000) && (div_cnt == lnk.divisor - 16'h0001);
  assign lnk.tx_ready = (tx_st == S_IDLE);
  assign lnk.tx_idle = (tx_st == S_IDLE);
  assign tx_last = tick && (tx_tk == BIT_LAST);
  assign rx_last = tick && (rx_tk == BIT_LAST);

  always_ff @(posedge aclk) begin
    if (!aresetn || tick || lnk.divisor == 16'h0000) div_cnt <= 16'h0000;
    else div_cnt <= div_cnt + 16'h0001;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_st <= S_IDLE;
      tx_tk <= 4'h0;
      tx_bit <= 3'h0;
      tx_sh <= BYTE_RESET;
      sout <= 1'b1;
    end else begin
      sout <= (tx_st == S_START) ? 1'b0 : (tx_st == S_DATA) ? tx_sh[0] : 1'b1;
      if (tick) tx_tk <= tx_tk + 4'h1;
      case (tx_st)
        S_IDLE: if (lnk.tx_valid) begin
          tx_sh <= lnk.tx_data;
          tx_tk <= 4'h0;
          tx_st <= S_START;
        end
        S_START: if (tx_last) begin
          tx_bit <= 3'h0;
          tx_st <= S_DATA;
        end
        S_DATA: if (tx_last) begin
          tx_sh <= {1'b0, tx_sh[7:1]};
          tx_bit <= tx_bit + 3'h1;
          if (tx_bit == 3'h7) tx_st <= S_STOP;
        end
        S_STOP: if (tx_last) tx_st <= S_IDLE;
        default: tx_st <= S_IDLE;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sin_meta <= 1'b1;
      sin_s <= 1'b1;
      rx_st <= S_IDLE;
      rx_tk <= 4'h0;
      rx_bit <= 3'h0;
      rx_sh <= BYTE_RESET;
      lnk.rx_valid <= 1'b0;
      lnk.rx_data <= BYTE_RESET;
    end else begin
      sin_meta <= sin;
      sin_s <= sin_meta;
      lnk.rx_valid <= (rx_st == S_STOP) && rx_last && sin_s;
      if ((rx_st == S_STOP) && rx_last) lnk.rx_data <= rx_sh;
      if (tick) rx_tk <= rx_tk + 4'h1;
      case (rx_st)
        S_IDLE: if (tick && !sin_s) begin
          rx_tk <= 4'h0;
          rx_st <= S_START;
        end
        // recentre on mid start bit, or drop a glitch
        S_START: if (tick && rx_tk == BIT_MID) begin
          rx_tk <= 4'h0;
          rx_bit <= 3'h0;
          rx_st <= sin_s ? S_IDLE : S_DATA;
        end
        S_DATA: if (rx_last) begin
          rx_sh <= {sin_s, rx_sh[7:1]};
          rx_bit <= rx_bit + 3'h1;
          if (rx_bit == 3'h7) rx_st <= S_STOP;
        end
        S_STOP: if (rx_last) rx_st <= S_IDLE;
        default: rx_st <= S_IDLE;
      endcase
    end
  end

  baud_stop_a: assert property (lnk.divisor == 16'h0000
    |-> !tick ##1 div_cnt == 16'h0000)
    else $error("baud tick while divisor is zero");
  start_bit_a: assert property (lnk.tx_valid && lnk.tx_ready
    |-> ##2 !sout)
    else $error("no start bit after transmit load");
endmodule : uart_serial_engine

// ### uart_far_end.sv
/*
  far-end serial device model: sends 8n1 frames on sin, decodes frames on sout.
  assumes a divisor of 1, so one bit lasts BIT_CYC aclk cycles; sin idles high.
*/
`timescale 1ns/1ps
module uart_far_end #(
  parameter int BIT_CYC = 16
) (
  input wire logic aclk,
  input wire logic sout,
  output logic sin,
  output logic [7:0] got,
  output logic got_stb
);
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge aclk);
      sin <= f[i];
      repeat (BIT_CYC - 1) @(posedge aclk);
    end
  endtask : send
  // decode at mid-bit; a frame with a low stop bit is not reported
  initial begin
    sin = 1'b1;
    got = 8'h00;
    got_stb = 1'b0;
    forever begin
      @(negedge sout);
      repeat (BIT_CYC / 2) @(posedge aclk);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT_CYC) @(posedge aclk);
        got[i] <= sout;
      end
      repeat (BIT_CYC) @(posedge aclk);
      if (sout) begin
        got_stb <= 1'b1;
        @(posedge aclk);
        got_stb <= 1'b0;
      end
    end
  end
endmodule : uart_far_end

// ### test_uart_rx_tx_data_port.sv
/*
  self-checking bench for the uart data port: axi4-lite master, far-end model.
  assumes the package register map and a divisor of 1 set through the data port.
*/
`timescale 1ns/1ps
module test_uart_rx_tx_data_port;
  import uart_port_pkg::*;
  localparam logic [33:0] FULL_M = 34'h3_ffff_ffff;
  localparam logic [33:0] BYTE_M = 34'h3_0000_00ff;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [31:0] awaddr, wdata, araddr, rdata, rnd;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic sin, sout, irq, got_stb;
  logic [7:0] got;
  logic [33:0] exp_q[$];
  logic [33:0] msk_q[$];
  logic [1:0] bq[$];
  logic [7:0] tx_q[$];
  logic [7:0] rx_b[$];
  int error_cnt = 0;
  int comparisons = 0;

  uart_data_port #(.FIFO_DEPTH(16)) u_dut (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .sin(sin), .sout(sout), .irq(irq)
  );
  uart_far_end #(.BIT_CYC(16)) u_far (.aclk(aclk), .sout(sout), .sin(sin), .got(got), .got_stb(got_stb));

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs

  task automatic chk(input logic [33:0] v, input logic [33:0] e);
    comparisons++;
    if (v !== e) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, v, e);
    end
  endtask : chk

  task automatic report_and_stop;
    if (error_cnt == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop

  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] r = RESP_OKAY);
    bq.push_back(r);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [31:0] a, input logic [33:0] e, input logic [33:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
  endtask : rd

  // waits for every queued frame, then long enough to catch a stray one
  task automatic wait_tx;
    for (int i = 0; i < 4000 && tx_q.size() > 0; i++) @(posedge aclk);
    repeat (200) @(posedge aclk);
  endtask : wait_tx

  // compares each read answer and each decoded frame with the oldest note
  always @(posedge aclk) begin
    if (rvalid && rready) chk({rresp, rdata} & msk_q.pop_front(), exp_q.pop_front());
    if (bvalid && bready) chk({32'h0, bresp}, {32'h0, bq.pop_front()});
    if (got_stb) chk({26'h0, got}, (tx_q.size() > 0) ? {26'h0, tx_q.pop_front()} : FULL_M);
  end

  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  initial begin
    repeat (20000) @(posedge aclk);
    error_cnt++;
    report_and_stop();
  end

  initial begin
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 32'h0;
    wdata = 32'h0;
    wstrb = 4'h0;
    araddr = 32'h0;
    rnd = 32'ha710;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rd(DATA_ADDR, {RESP_OKAY, 16'h0, DATA_RESET}, FULL_M);
    rd(32'h5000_1ffc, {RESP_SLVERR, 32'h0}, FULL_M);
    wr(32'h5000_1ffc, 32'h0, RESP_SLVERR);
    rd(LSR_ADDR, 34'h60, 34'h63);
    wr(LCR_ADDR, 32'h80);
    wr(DATA_ADDR, 32'h01);
    rd(DATA_ADDR, 34'h01, BYTE_M);
    wr(LCR_ADDR, 32'h00);
    wr(IRQ_EN_ADDR, 32'h7);
    // fifos off: the first byte leaves at once, the third replaces the second
    rnd = xs(rnd);
    tx_q.push_back(rnd[7:0]);
    wr(DATA_ADDR, {24'h0, rnd[7:0]});
    rnd = xs(rnd);
    wr(DATA_ADDR, {24'h0, rnd[7:0]});
    rd(LSR_ADDR, 34'h0, 34'h20);
    rnd = xs(rnd);
    tx_q.push_back(rnd[7:0]);
    wr(DATA_ADDR, {24'h0, rnd[7:0]});
    wait_tx();
    // fifos off: two frames without a read, the second overwrites
    rnd = xs(rnd);
    u_far.send(rnd[7:0]);
    rnd = xs(rnd);
    u_far.send(rnd[7:0]);
    repeat (4) @(posedge aclk);
    rd(LSR_ADDR, 34'h3, 34'h3);
    rd(DATA_ADDR, {26'h0, rnd[7:0]}, BYTE_M);
    rd(LSR_ADDR, 34'h0, 34'h3);
    rd(IRQ_STAT_ADDR, 34'h7, 34'h7);
    chk({33'h0, irq}, 34'h1);
    wr(IRQ_EN_ADDR, 32'h0);
    chk({33'h0, irq}, 34'h0);
    wr(IRQ_EN_ADDR, 32'h7);
    wr(IRQ_CLR_ADDR, 32'h7);
    chk({33'h0, irq}, 34'h0);
    // fifos on: seventeen frames into a sixteen-deep queue
    wr(FCR_ADDR, 32'h1);
    for (int i = 0; i < 17; i++) begin
      rnd = xs(rnd);
      if (i < 16) rx_b.push_back(rnd[7:0]);
      u_far.send(rnd[7:0]);
    end
    repeat (4) @(posedge aclk);
    rd(LSR_ADDR, 34'h3, 34'h3);
    for (int i = 0; i < 16; i++) rd(DATA_ADDR, {26'h0, rx_b.pop_front()}, BYTE_M);
    rd(LSR_ADDR, 34'h0, 34'h1);
    // one byte goes straight to the shifter, sixteen queue, the rest are lost
    for (int i = 0; i < 20; i++) begin
      rnd = xs(rnd);
      if (i < 17) tx_q.push_back(rnd[7:0]);
      wr(DATA_ADDR, {24'h0, rnd[7:0]});
    end
    wait_tx();
    report_and_stop();
  end
endmodule : test_uart_rx_tx_data_port
